// ### basic_eight_bit_timer.sv
`timescale 1ns/1ps
`default_nettype none
module basic_eight_bit_timer #(
  parameter int COUNT_WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [basic_timer_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [basic_timer_pkg::DATA_W-1:0] i_pwdata,
  input wire logic i_fcpu_tick,
  input wire logic i_green_mode,
  output logic [basic_timer_pkg::DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq,
  output logic [7:0] o_irq_vector,
  output logic o_wakeup,
  output logic o_timeout
);

  if (COUNT_WIDTH != basic_timer_pkg::CNT_W) begin : g_width_check
    $error("Counter width must be eight");
  end

  basic_timer_pkg::timer_mode_t mode_reg;
  logic [COUNT_WIDTH-1:0] count_reg;
  logic [7:0] pre_reg;
  basic_timer_pkg::timer_events_t status_reg;
  basic_timer_pkg::timer_events_t mask_reg;

  logic setup;
  logic wr_done;
  logic [7:0] idx;
  logic hit_mode, hit_count, hit_status, hit_mask, hit_req, hit_any;
  logic [7:0] pre_limit;
  logic tick;
  logic overflow;
  logic wake_ev;
  basic_timer_pkg::timer_events_t w1c;
  logic req_clear;
  logic [basic_timer_pkg::DATA_W-1:0] rd_next;

  assign setup = i_psel && !i_penable;
  assign wr_done = i_psel && i_penable && o_pready && i_pwrite;
  assign idx = i_paddr[9:2];

  always_comb begin
    hit_mode = 1'b0;
    hit_count = 1'b0;
    hit_status = 1'b0;
    hit_mask = 1'b0;
    hit_req = 1'b0;
    if (i_paddr[1:0] != basic_timer_pkg::IDX_LSB_PAD || i_paddr[11:10] != 2'h0) begin
      hit_mode = 1'b0;
    end else if (idx == basic_timer_pkg::MODE_IDX) begin
      hit_mode = 1'b1;
    end else if (idx == basic_timer_pkg::COUNT_IDX) begin
      hit_count = 1'b1;
    end else if (idx == basic_timer_pkg::STATUS_IDX) begin
      hit_status = 1'b1;
    end else if (idx == basic_timer_pkg::MASK_IDX) begin
      hit_mask = 1'b1;
    end else if (idx == basic_timer_pkg::REQ_IDX) begin
      hit_req = 1'b1;
    end
  end

  assign hit_any = hit_mode | hit_count | hit_status | hit_mask | hit_req;

  assign pre_limit = basic_timer_pkg::PRE_FULL >> mode_reg.div_sel;
  assign tick = mode_reg.run && i_fcpu_tick && (pre_reg == pre_limit);
  // wrap from all ones to zero
  assign overflow = tick && (count_reg == basic_timer_pkg::COUNT_MAX);
  // wake only when running in green mode
  assign wake_ev = overflow && mode_reg.run && i_green_mode;

  // writing zero to the request bit clears the flag
  assign req_clear = wr_done && hit_req && !i_pwdata[basic_timer_pkg::OVF_BIT];
  assign w1c = (wr_done && hit_status) ? i_pwdata[basic_timer_pkg::EV_W-1:0]
                                        : basic_timer_pkg::EV_RESET;

  always_comb begin
    rd_next = '0;
    if (hit_mode) begin
      rd_next[7:0] = {mode_reg.run, mode_reg.div_sel, 4'h0};
    end else if (hit_count) begin
      rd_next[7:0] = count_reg;
    end else if (hit_status) begin
      rd_next[basic_timer_pkg::EV_W-1:0] = status_reg;
    end else if (hit_mask) begin
      rd_next[basic_timer_pkg::EV_W-1:0] = mask_reg;
    end else if (hit_req) begin
      rd_next[basic_timer_pkg::OVF_BIT] = status_reg.ovf;
    end
  end

  // APB answer: no wait state, pready high in the first access cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup && !hit_any;
      if (setup) begin
        o_prdata <= i_pwrite ? '0 : rd_next;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_reg <= basic_timer_pkg::MODE_RESET;
    end else if (wr_done && hit_mode) begin
      mode_reg.run <= i_pwdata[basic_timer_pkg::RUN_BIT];
      mode_reg.div_sel <= i_pwdata[basic_timer_pkg::SEL_LSB +: basic_timer_pkg::SEL_W];
      mode_reg.unused <= 4'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !mode_reg.run) begin
      pre_reg <= 8'h00;
    end else if (tick) begin
      pre_reg <= 8'h00;
    end else if (i_fcpu_tick) begin
      pre_reg <= pre_reg + 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_reg <= basic_timer_pkg::COUNT_RESET;
    end else if (wr_done && hit_count) begin
      count_reg <= i_pwdata[COUNT_WIDTH-1:0];
    end else if (tick) begin
      // no reload, runs on from zero
      count_reg <= count_reg + 8'h01;
    end
  end

  // overflow sets the flag; a set wins over a clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status_reg <= basic_timer_pkg::EV_RESET;
    end else begin
      status_reg.ovf <= overflow || (status_reg.ovf && !w1c.ovf && !req_clear);
      status_reg.wake <= wake_ev || (status_reg.wake && !w1c.wake);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mask_reg <= basic_timer_pkg::EV_RESET;
    end else if (wr_done && hit_mask) begin
      mask_reg <= i_pwdata[basic_timer_pkg::EV_W-1:0];
    end
  end

  // interrupt request and vector to the core
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
      o_irq_vector <= basic_timer_pkg::NO_VECTOR;
    end else begin
      o_irq <= |(status_reg & mask_reg);
      o_irq_vector <= (status_reg.ovf && mask_reg.ovf) ? basic_timer_pkg::IRQ_VECTOR
                                                       : basic_timer_pkg::NO_VECTOR;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_timeout <= 1'b0;
      o_wakeup <= 1'b0;
    end else begin
      o_timeout <= overflow;
      o_wakeup <= wake_ev;
    end
  end

endmodule
`default_nettype wire

// ### basic_eight_bit_timer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module basic_eight_bit_timer_asserts (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_fcpu_tick,
  input wire logic i_green_mode,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_irq,
  input wire logic [7:0] o_irq_vector,
  input wire logic o_wakeup,
  input wire logic o_timeout
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_answer;
    o_pready ##1 !o_pready;
  endsequence
  AST_SETUP_ANSWER: assert property (s_setup |=> s_answer)
    else $error("pready not one cycle after setup");
  AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  AST_TIMEOUT_SPACED: assert property (o_timeout |=> !o_timeout [*8])
    else $error("timeouts too close");
  AST_TIMEOUT_TICK: assert property (o_timeout |-> $past(i_fcpu_tick))
    else $error("timeout without fcpu tick");
  AST_WAKE_TIMEOUT: assert property (o_wakeup |-> o_timeout)
    else $error("wakeup without overflow");
  AST_WAKE_GREEN: assert property (o_wakeup |-> $past(i_green_mode))
    else $error("wakeup outside green mode");
  AST_VECTOR_CODE: assert property (o_irq_vector == 8'h00 || o_irq_vector == 8'h08)
    else $error("bad vector value");
  AST_VECTOR_IRQ: assert property (o_irq_vector == 8'h08 |-> o_irq)
    else $error("vector without irq");
endmodule
bind basic_eight_bit_timer basic_eight_bit_timer_asserts i_chk (.i_clk, .i_rst, .i_psel,
  .i_penable, .i_fcpu_tick, .i_green_mode, .o_pready, .o_pslverr, .o_irq, .o_irq_vector,
  .o_wakeup, .o_timeout);
`default_nettype wire

// ### basic_eight_bit_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
module basic_eight_bit_timer_test;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic i_fcpu_tick = 1'b0;
  logic i_green_mode = 1'b0;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_irq, o_wakeup, o_timeout;
  logic [7:0] o_irq_vector;
  logic [31:0] rdat;
  logic serr;
  int fail_count = 0;
  int n_compared = 0;
  int n;
  always #12.5 i_clk = ~i_clk;
  basic_eight_bit_timer i_dut (.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .i_fcpu_tick, .i_green_mode, .o_prdata, .o_pready, .o_pslverr, .o_irq,
    .o_irq_vector, .o_wakeup, .o_timeout);
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1 && ++k < 20);
    if (o_pready !== 1'b1) begin
      fail_count++;
      $display("FAIL %0t: no pready", $time);
    end
    rdat = o_prdata;
    serr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic wait_on(ref logic s);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (s !== 1'b1 && n < 1000);
    if (s !== 1'b1) begin
      fail_count++;
      $display("FAIL %0t: event never came", $time);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #250000;
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    i_fcpu_tick <= 1'b1;
    rd(12'h360, 32'h0);
    rd(12'h364, 32'h0);
    wr(12'h364, 32'hA5);
    rd(12'h364, 32'hA5);
    wr(12'h360, 32'h70);
    rd(12'h360, 32'h70);
    xfer(1'b0, 12'h368, 32'h0);
    chk({31'h0, serr}, 32'h1);
    for (int s = 0; s < 8; s++) begin
      wr(12'h360, 32'h0);
      wr(12'h364, 32'hFE);
      wr(12'h360, 32'h80 | (s << 4));
      wait_on(o_timeout);
      chk(n, (2 << (8 - s)) + 1);
    end
    chk({31'h0, o_irq}, 32'h0);
    rd(12'h378, 32'h1);
    wr(12'h378, 32'h0);
    rd(12'h378, 32'h0);
    wr(12'h374, 32'h1);
    wait_on(o_irq);
    chk({24'h0, o_irq_vector}, 32'h8);
    wr(12'h370, 32'h1);
    repeat (2) @(negedge i_clk);
    chk({31'h0, o_irq}, 32'h0);
    @(posedge i_clk);
    i_green_mode <= 1'b1;
    wait_on(o_timeout);
    wait_on(o_wakeup);
    chk(n, 32'd512);
    rd(12'h370, 32'h3);
    wr(12'h360, 32'h0);
    wr(12'h364, 32'h5A);
    repeat (8) @(posedge i_clk);
    rd(12'h364, 32'h5A);
    end_sim();
  end
endmodule
`default_nettype wire

// ### basic_timer_pkg.sv
// Function
// - Eight-bit up counter wraps from all ones to zero, signals time-out, keeps counting.
// - Each wrap from maximum to zero sets the overflow request flag.
// - Overflow with interrupt enabled directs the core to the vector at address 8.
// - Mode bit 7 is the run bit: one starts counting, zero stops.
// - Divider select 000 divides by 256, each step halves, 111 divides by 2.
// - Divider select field sits in mode register bits four to six.
// - Count tick comes only from the instruction clock divided by 2 to 256.
// - Counting continues while the system is in green low-power mode.
// - With run bit set, overflow in green mode raises a wake-up.
// - No automatic reload; after overflow counting continues from zero.
// - Count register is eight-bit read/write; a write sets the present count.
// - Software clears the overflow request flag by writing zero, before enabling.
package basic_timer_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W = 8;
  localparam int SEL_W = 3;

  // Register indices; byte address is four times the index
  localparam logic [7:0] MODE_IDX = 8'hD8;
  localparam logic [7:0] COUNT_IDX = 8'hD9;
  localparam logic [7:0] STATUS_IDX = 8'hDC;
  localparam logic [7:0] MASK_IDX = 8'hDD;
  localparam logic [7:0] REQ_IDX = 8'hDE;

  localparam logic [1:0] IDX_LSB_PAD = 2'h0;

  // Field positions
  localparam int RUN_BIT = 7;
  localparam int SEL_LSB = 4;
  localparam int OVF_BIT = 0;
  localparam int WAKE_BIT = 1;
  localparam int EV_W = 2;

  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] PRE_FULL = 8'hFF;
  localparam logic [EV_W-1:0] EV_RESET = 2'h0;
  localparam logic [7:0] IRQ_VECTOR = 8'h08;
  localparam logic [7:0] NO_VECTOR = 8'h00;

  typedef struct packed {
    logic run;
    logic [SEL_W-1:0] div_sel;
    logic [3:0] unused;
  } timer_mode_t;

  typedef struct packed {
    logic wake;
    logic ovf;
  } timer_events_t;

endpackage
